// [shared/tx_status_pkg.sv]
// package of register map, reset values and field positions for the vucp gen
// Summary of operation
// - validity is 0 unless receiver source or validity override applies
// - source 00 passes the recovered validity bit through unless validity override is set
// - override sends the first-half value or second-half value per sub-frame
// - user bit is 0 locally, recovered user bit when source is 00
// - one status bit per sub-frame, each sub-frame its own 192-frame block
// - only status bits 0 to 39 come from configuration, the rest are 0
// - both sub-frames send the same status, channel number 23:20 included
// - source 00 repeats recovered status unless status override is set
// - parity bit makes the sub-frame content even parity
// - status bit 0 from register bit 0, reset 0, software keeps it 0
// - status bit 1 is the non-pcm flag, reset 0
// - status bit 2 is the copy permit flag, reset 0
// - status bits 5:3 carry emphasis; software writes only 000 or 001
// - status bits 15:8 carry category, reset 00h
// - status bits 19:16 carry source number, reset 0
// - channel number 21:20 first half, 23:22 second half, reset 00
// - status bits 27:24 carry sample rate indication, reset 0001
// - status bits 29:28 carry clock accuracy, reset 11
// - each configurable status bit comes from its register field
// - source select 00 rx, 01 adc, 10 secondary, 11 primary, reset 00
package tx_status_pkg;
    localparam logic [7:0] addr_control = 8'h1E;
    localparam logic [7:0] addr_flags = 8'h1F;
    localparam logic [7:0] addr_category = 8'h20;
    localparam logic [7:0] addr_source_channel = 8'h21;
    localparam logic [7:0] addr_rate_accuracy = 8'h22;
    localparam logic [7:0] addr_word_length = 8'h23;
    localparam logic [7:0] addr_position = 8'h24;
    localparam logic [7:0] rst_control = 8'h00;
    localparam logic [7:0] rst_flags = 8'h00;
    localparam logic [7:0] rst_category = 8'h00;
    localparam logic [7:0] rst_source_channel = 8'h00;
    localparam logic [7:0] rst_rate_accuracy = 8'h31;
    localparam logic [7:0] rst_word_length = 8'h0B;
    localparam int ctl_source_lsb = 0;
    localparam int ctl_status_ovr = 2;
    localparam int ctl_valid_ovr = 4;
    localparam int ctl_valid_first = 5;
    localparam int ctl_valid_second = 6;
    localparam logic [1:0] src_receiver = 2'h0;
    localparam logic [1:0] src_adc = 2'h1;
    localparam logic [1:0] src_secondary = 2'h2;
    localparam logic [1:0] src_primary = 2'h3;
    localparam int block_frames = 192;
    localparam int config_bits = 40;
    localparam int chan_num_lsb = 20;
    localparam int chan_second_lsb = 22;
endpackage : tx_status_pkg

// [hdl/vucp_gen.sv]
// validity, user, channel status and parity generation for the transmitter
module vucp_gen (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sub_req,
    input wire logic sub_second,
    input wire logic block_start,
    input wire logic [23:0] audio_word,
    input wire logic rx_validity,
    input wire logic rx_user,
    input wire logic rx_status,
    output logic sub_valid,
    output logic validity_bit,
    output logic user_bit,
    output logic status_bit,
    output logic parity_bit,
    output logic [1:0] tx_source_select
);
    import tx_status_pkg::*;

    logic [7:0] control;
    logic [7:0] flags;
    logic [7:0] category;
    logic [7:0] source_channel;
    logic [7:0] rate_accuracy;
    logic [7:0] word_length;
    logic [7:0] frame_pos;
    logic validity_override_enable;
    logic validity_value_first_half;
    logic validity_value_second_half;
    logic status_override_enable;
    logic consumer_professional_flag;
    logic copy_permit_flag;
    logic [2:0] emphasis_field;
    logic [1:0] status_mode_field;
    logic [1:0] channel_number_first;
    logic [1:0] channel_number_second;
    logic max_length_flag;
    logic [2:0] sample_length_code;
    logic [3:0] original_rate_field;
    logic [39:0] block_first;
    logic [39:0] block_second;
    logic [7:0] pos_now;
    logic from_receiver;
    logic next_validity;
    logic next_user;
    logic next_status;
    logic local_status;
    logic [39:0] block_sel;

    // control field views
    assign tx_source_select = control[ctl_source_lsb +: 2];
    assign status_override_enable = control[ctl_status_ovr];
    assign validity_override_enable = control[ctl_valid_ovr];
    assign validity_value_first_half = control[ctl_valid_first];
    assign validity_value_second_half = control[ctl_valid_second];
    assign consumer_professional_flag = flags[0];
    assign copy_permit_flag = flags[2];
    assign emphasis_field = flags[5:3];
    assign status_mode_field = flags[7:6];
    assign channel_number_first = source_channel[5:4];
    assign channel_number_second = source_channel[7:6];
    assign max_length_flag = word_length[0];
    assign sample_length_code = word_length[3:1];
    assign original_rate_field = word_length[7:4];
    assign from_receiver = (tx_source_select == src_receiver);

    // status block images; both halves use the same image, channel number included
    assign block_first = {original_rate_field, sample_length_code,
        max_length_flag, 2'h0, rate_accuracy[5:0],
        channel_number_second, channel_number_first,
        source_channel[3:0], category, status_mode_field,
        emphasis_field, copy_permit_flag, flags[1],
        consumer_professional_flag};
    assign block_second = block_first;
    assign block_sel = sub_second ? block_second : block_first;

    // block position, restarted by the frame marker
    assign pos_now = block_start ? 8'h00 : frame_pos;
    assign local_status = (pos_now < 8'(config_bits)) ?
        block_sel[pos_now[5:0]] : 1'b0;
    assign next_status = (from_receiver && !status_override_enable) ?
        rx_status : local_status;

    // validity and user selection
    assign next_validity = validity_override_enable ?
        (sub_second ? validity_value_second_half
                    : validity_value_first_half)
        : (from_receiver ? rx_validity : 1'b0);
    assign next_user = from_receiver ? rx_user : 1'b0;

    // register writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            control <= rst_control;
            flags <= rst_flags;
            category <= rst_category;
            source_channel <= rst_source_channel;
            rate_accuracy <= rst_rate_accuracy;
            word_length <= rst_word_length;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == addr_control) begin
                control <= {1'b0, reg_wdata[6:4], 1'b0, reg_wdata[2:0]};
            end else if (reg_addr == addr_flags) begin
                flags <= reg_wdata;
            end else if (reg_addr == addr_category) begin
                category <= reg_wdata;
            end else if (reg_addr == addr_source_channel) begin
                source_channel <= reg_wdata;
            end else if (reg_addr == addr_rate_accuracy) begin
                rate_accuracy <= {2'h0, reg_wdata[5:0]};
            end else if (reg_addr == addr_word_length) begin
                word_length <= reg_wdata;
            end
        end
    end

    // register reads, one cycle later; unmapped reads return zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            if (!reg_rd) reg_rdata <= 8'h00;
            else if (reg_addr == addr_control) reg_rdata <= control;
            else if (reg_addr == addr_flags) reg_rdata <= flags;
            else if (reg_addr == addr_category) reg_rdata <= category;
            else if (reg_addr == addr_source_channel)
                reg_rdata <= source_channel;
            else if (reg_addr == addr_rate_accuracy)
                reg_rdata <= rate_accuracy;
            else if (reg_addr == addr_word_length) reg_rdata <= word_length;
            else if (reg_addr == addr_position) reg_rdata <= frame_pos;
            else reg_rdata <= 8'h00;
        end
    end

    // frame counter advances after each second sub-frame
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            frame_pos <= 8'h00;
        end else if (clk_en && sub_req && sub_second) begin
            frame_pos <= (pos_now == 8'(block_frames - 1)) ? 8'h00
                : pos_now + 8'h01;
        end else if (clk_en && block_start && sub_req) begin
            frame_pos <= 8'h00;
        end
    end

    // registered vucp outputs with even parity over bits 4..31
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sub_valid <= 1'b0;
            validity_bit <= 1'b0;
            user_bit <= 1'b0;
            status_bit <= 1'b0;
            parity_bit <= 1'b0;
        end else if (clk_en) begin
            sub_valid <= sub_req;
            if (sub_req) begin
                validity_bit <= next_validity;
                user_bit <= next_user;
                status_bit <= next_status;
                parity_bit <= ^{audio_word, next_validity, next_user,
                    next_status};
            end
        end
    end

    // vucp is fixed for each sub-frame once given
    property p_parity_even;
        @(posedge clk) disable iff (sys_rst)
        (sub_valid && $past(clk_en)) |-> ((^{validity_bit, user_bit,
            status_bit, parity_bit, $past(audio_word)}) == 1'b0);
    endproperty
    a_parity_even: assert property (p_parity_even)
        else $error("sub-frame parity not even");

    property p_local_user;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && sub_req && !from_receiver) |=> (user_bit == 1'b0);
    endproperty
    a_local_user: assert property (p_local_user)
        else $error("user bit set for local source");

    property p_valid_override;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && sub_req && validity_override_enable) |=>
        (validity_bit == ($past(sub_second) ? $past(control[6])
                                            : $past(control[5])));
    endproperty
    a_valid_override: assert property (p_valid_override)
        else $error("validity override value not sent");

    property p_valid_default;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && sub_req && !validity_override_enable && !from_receiver)
        |=> !validity_bit;
    endproperty
    a_valid_default: assert property (p_valid_default)
        else $error("validity not zero by default");

    property p_valid_rx;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && sub_req && !validity_override_enable && from_receiver)
        |=> (validity_bit == $past(rx_validity));
    endproperty
    a_valid_rx: assert property (p_valid_rx)
        else $error("recovered validity not passed");

    property p_status_rx;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && sub_req && from_receiver && !status_override_enable)
        |=> (status_bit == $past(rx_status));
    endproperty
    a_status_rx: assert property (p_status_rx)
        else $error("recovered status not repeated");

    property p_status_tail;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && sub_req && pos_now >= 8'(config_bits) &&
         !(from_receiver && !status_override_enable)) |=> !status_bit;
    endproperty
    a_status_tail: assert property (p_status_tail)
        else $error("status bit beyond 40 not zero");

    property p_pos_range;
        @(posedge clk) disable iff (sys_rst)
        frame_pos < 8'(block_frames);
    endproperty
    a_pos_range: assert property (p_pos_range)
        else $error("frame position past block end");

    property p_cat_bit;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && sub_req && pos_now == 8'h08 && !from_receiver) |=>
        (status_bit == $past(category[0]));
    endproperty
    a_cat_bit: assert property (p_cat_bit)
        else $error("category bit misplaced");

    // a request whose status bit comes from the local registers
    sequence s_local_bit;
        clk_en && sub_req && !(from_receiver && !status_override_enable);
    endsequence

    sequence s_take;
        clk_en && sub_req;
    endsequence

    // each configured status bit comes from its own register field
    property p_pro_flag;
        @(posedge clk) disable iff (sys_rst)
        s_local_bit ##0 (pos_now == 8'h00) |=>
        (status_bit == $past(flags[0]));
    endproperty
    a_pro_flag: assert property (p_pro_flag)
        else $error("status bit 0 not from flag register");

    property p_nonpcm_flag;
        @(posedge clk) disable iff (sys_rst)
        s_local_bit ##0 (pos_now == 8'h01) |=>
        (status_bit == $past(flags[1]));
    endproperty
    a_nonpcm_flag: assert property (p_nonpcm_flag)
        else $error("non-pcm status bit misplaced");

    property p_copy_flag;
        @(posedge clk) disable iff (sys_rst)
        s_local_bit ##0 (pos_now == 8'h02) |=>
        (status_bit == $past(flags[2]));
    endproperty
    a_copy_flag: assert property (p_copy_flag)
        else $error("copy status bit misplaced");

    property p_emphasis;
        @(posedge clk) disable iff (sys_rst)
        s_local_bit ##0 (pos_now >= 8'h03 && pos_now <= 8'h05) |=>
        (status_bit == $past(flags[pos_now[2:0]]));
    endproperty
    a_emphasis: assert property (p_emphasis)
        else $error("emphasis status bits misplaced");

    property p_category_bits;
        @(posedge clk) disable iff (sys_rst)
        s_local_bit ##0 (pos_now >= 8'h08 && pos_now <= 8'h0F) |=>
        (status_bit == $past(category[pos_now[2:0]]));
    endproperty
    a_category_bits: assert property (p_category_bits)
        else $error("category status bits misplaced");

    property p_source_bits;
        @(posedge clk) disable iff (sys_rst)
        s_local_bit ##0 (pos_now >= 8'h10 && pos_now <= 8'h13) |=>
        (status_bit == $past(source_channel[pos_now[1:0]]));
    endproperty
    a_source_bits: assert property (p_source_bits)
        else $error("source number status bits misplaced");

    property p_chan_bits;
        @(posedge clk) disable iff (sys_rst)
        s_local_bit ##0 (pos_now >= 8'h14 && pos_now <= 8'h17) |=>
        (status_bit == $past(source_channel[{1'h1, pos_now[1:0]}]));
    endproperty
    a_chan_bits: assert property (p_chan_bits)
        else $error("channel number status bits misplaced");

    property p_rate_bits;
        @(posedge clk) disable iff (sys_rst)
        s_local_bit ##0 (pos_now >= 8'h18 && pos_now <= 8'h1B) |=>
        (status_bit == $past(rate_accuracy[pos_now[1:0]]));
    endproperty
    a_rate_bits: assert property (p_rate_bits)
        else $error("sample rate status bits misplaced");

    property p_accuracy_bits;
        @(posedge clk) disable iff (sys_rst)
        s_local_bit ##0 (pos_now >= 8'h1C && pos_now <= 8'h1D) |=>
        (status_bit == $past(rate_accuracy[{2'h2, pos_now[0]}]));
    endproperty
    a_accuracy_bits: assert property (p_accuracy_bits)
        else $error("clock accuracy status bits misplaced");

    property p_length_bits;
        @(posedge clk) disable iff (sys_rst)
        s_local_bit ##0 (pos_now >= 8'h20 && pos_now <= 8'h27) |=>
        (status_bit == $past(word_length[pos_now[2:0]]));
    endproperty
    a_length_bits: assert property (p_length_bits)
        else $error("word length status bits misplaced");

    // request handshake, block position and clock enable
    property p_sub_pulse;
        @(posedge clk) disable iff (sys_rst)
        s_take |=> sub_valid;
    endproperty
    a_sub_pulse: assert property (p_sub_pulse)
        else $error("request not answered");

    property p_sub_idle;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && !sub_req) |=> !sub_valid;
    endproperty
    a_sub_idle: assert property (p_sub_idle)
        else $error("sub-frame answer without request");

    property p_first_half_hold;
        @(posedge clk) disable iff (sys_rst)
        s_take ##0 (!sub_second && !block_start) |=>
        $stable(frame_pos);
    endproperty
    a_first_half_hold: assert property (p_first_half_hold)
        else $error("position moved between the two halves");

    property p_block_restart;
        @(posedge clk) disable iff (sys_rst)
        s_take ##0 (block_start && !sub_second) |=>
        (frame_pos == 8'h00);
    endproperty
    a_block_restart: assert property (p_block_restart)
        else $error("block start did not restart position");

    property p_second_step;
        @(posedge clk) disable iff (sys_rst)
        s_take ##0 sub_second |=>
        (frame_pos == (($past(pos_now) == 8'(block_frames - 1)) ? 8'h00
            : $past(pos_now) + 8'h01));
    endproperty
    a_second_step: assert property (p_second_step)
        else $error("position did not step after second half");

    property p_user_rx;
        @(posedge clk) disable iff (sys_rst)
        s_take ##0 from_receiver |=>
        (user_bit == $past(rx_user));
    endproperty
    a_user_rx: assert property (p_user_rx)
        else $error("recovered user bit not passed");

    property p_freeze;
        @(posedge clk) disable iff (sys_rst)
        !clk_en |=> ($stable(frame_pos) && $stable(sub_valid)
            && $stable(status_bit) && $stable(flags));
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");

endmodule : vucp_gen

// [test/rcv_model.sv]
// receiving-end model: checks parity and gathers status blocks
module rcv_model (
    input wire logic clk,
    input wire logic sub_req,
    input wire logic sub_second,
    input wire logic [23:0] audio_word,
    input wire logic sub_valid,
    input wire logic validity_bit,
    input wire logic user_bit,
    input wire logic status_bit,
    input wire logic parity_bit,
    output logic [191:0] cs_a,
    output logic [191:0] cs_b,
    output int parity_errs
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] word_q = '0;
    logic half_q = 1'b0;
    int errs = 0;
    // error count handed out through one continuous driver
    assign parity_errs = errs;
    // keep the payload and half that went with the request
    always @(posedge clk) begin
        if (sub_req) begin
            word_q <= audio_word;
            half_q <= sub_second;
        end
    end
    // each half shifts one status bit in per sub-frame, frame 0 ends at bit 0
    always @(posedge clk) begin
        if (sub_valid) begin
            if ((^{word_q, validity_bit, user_bit, status_bit,
                parity_bit}) !== 1'b0)
                errs <= errs + 1;
            if (half_q)
                cs_b <= {status_bit, cs_b[191:1]};
            else
                cs_a <= {status_bit, cs_a[191:1]};
        end
    end
endmodule : rcv_model

// [test/test_vucp_gen.sv]
// self-checking bench for the status bit generator
module test_vucp_gen;
    timeunit 1ns;
    timeprecision 1ps;
    import tx_status_pkg::*;
    logic clk, sys_rst, clk_en, reg_wr, reg_rd, sub_req, sub_second;
    logic block_start, rx_validity, rx_user, rx_status, sub_valid;
    logic validity_bit, user_bit, status_bit, parity_bit;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, ctl;
    logic [23:0] audio_word;
    logic [1:0] tx_source_select;
    logic [191:0] cs_a, cs_b, pa, pb;
    logic [39:0] cfg;
    int parity_errs, failures, n_tests;
    // address and reset value, last row unmapped
    logic [15:0] rst_rows [7] = '{16'h1E00, 16'h1F00, 16'h2000, 16'h2100,
        16'h2231, 16'h230B, 16'h3000};
    logic [7:0] ctl_rows [8] = '{8'h04, 8'h01, 8'h02, 8'h03, 8'h00,
        8'h30, 8'h51, 8'h74};
    vucp_gen dut_u (.clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .sub_req, .sub_second, .block_start,
        .audio_word, .rx_validity, .rx_user, .rx_status, .sub_valid,
        .validity_bit, .user_bit, .status_bit, .parity_bit,
        .tx_source_select);
    rcv_model rx_u (.clk, .sub_req, .sub_second, .audio_word, .sub_valid,
        .validity_bit, .user_bit, .status_bit, .parity_bit, .cs_a, .cs_b,
        .parity_errs);
    task automatic chk(input logic [191:0] got, input logic [191:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rd
    // one sub-frame request with recovered bits made from the frame index
    task automatic sub(input int i, input logic h);
        logic rxs;
        @(posedge clk);
        sub_req <= 1'b1;
        sub_second <= h;
        block_start <= (i == 0) && !h;
        audio_word <= {i[7:0], 8'h5C, i[6:0], h};
        rx_validity <= i[1];
        rx_user <= i[2];
        rx_status <= i[0] ^ h;
        @(posedge clk);
        sub_req <= 1'b0;
        #1;
        rxs = (ctl[1:0] == 2'b00);
        chk(sub_valid, 1'b1);
        chk(validity_bit, ctl[4] ? ctl[5 + h] : rxs && i[1]);
        chk(user_bit, rxs && i[2]);
    endtask : sub
    // one whole block of 192 frames under one control setting
    task automatic run_block(input logic [7:0] c);
        ctl = c;
        wr(addr_control, c);
        rd(addr_control, c & 8'h77);
        for (int i = 0; i < 192; i++) begin
            sub(i, 1'b0);
            sub(i, 1'b1);
            pa[i] = i[0];
            pb[i] = !i[0];
        end
        @(posedge clk);
        #1;
        if (c[1:0] != 2'b00 || c[2]) begin
            pa = {152'b0, cfg};
            pb = pa;
        end
        chk(cs_a, pa);
        chk(cs_b, pb);
        chk(tx_source_select, c[1:0]);
        chk(parity_errs, 0);
        $display("block with control %0h done", c);
    endtask : run_block
    task automatic report_and_stop();
        $display("%0d compares, %0d failures", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // watchdog well past the expected run of about 0.4 milliseconds
    initial begin
        #2_000_000;
        failures++;
        report_and_stop();
    end
    initial begin
        {sys_rst, clk_en, reg_wr, reg_rd, sub_req, sub_second} = 6'b110000;
        {block_start, rx_validity, rx_user, rx_status} = 4'b0;
        {reg_addr, reg_wdata, audio_word, ctl} = '0;
        failures = 0;
        n_tests = 0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (rst_rows[k]) rd(rst_rows[k][15:8], rst_rows[k][7:0]);
        $display("register reset values done");
        sub(5, 1'b0);
        sub(5, 1'b1);
        cfg = 40'h0B_31_00_00_00;
        run_block(8'h01);
        wr(addr_rate_accuracy, 8'hFF);
        rd(addr_rate_accuracy, 8'h3F);
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h00);
        wr(addr_flags, 8'h0E);
        wr(addr_category, 8'h5A);
        wr(addr_source_channel, 8'h93);
        wr(addr_rate_accuracy, 8'h22);
        wr(addr_word_length, 8'hA5);
        rd(addr_word_length, 8'hA5);
        cfg = 40'hA5_22_93_5A_0E;
        foreach (ctl_rows[k]) run_block(ctl_rows[k]);
        run_block(8'hFF);
        sub(3, 1'b0);
        sub(3, 1'b1);
        // frozen clock enable: a write and a request are both ignored
        @(posedge clk);
        clk_en <= 1'b0;
        wr(addr_category, 8'hC3);
        @(posedge clk);
        sub_req <= 1'b1;
        @(posedge clk);
        sub_req <= 1'b0;
        #1 chk(sub_valid, 1'b0);
        @(posedge clk);
        clk_en <= 1'b1;
        rd(addr_category, 8'h5A);
        rd(addr_position, 8'h01);
        $display("clock enable freeze done");
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(addr_category, 8'h00);
        rd(addr_flags, 8'h00);
        rd(addr_rate_accuracy, 8'h31);
        rd(addr_control, 8'h00);
        rd(addr_position, 8'h00);
        $display("second reset done");
        report_and_stop();
    end
endmodule : test_vucp_gen
